/* File: pss_pair_sample.sv */
/*
 * pss_pair_sample: pair sample mode control, slot dispatch and result capture.
 * Assumes an APB master, a slot sequencer and a conversion core on pclk.
 */
module pss_pair_sample
	import pss_pkg::*;
#(
	parameter int DATA_W = RESULT_W
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire pss_slot_req_t       slot_req,
	output logic                     slot_ready,
	output pss_core_cmd_t            core_cmd,
	input  wire pss_core_rsp_t       core_rsp,
	output logic [NUM_SLOTS-1:0]     conversion_done_event,
	output logic [MODE_WIDTH-1:0]    pair_sample_mode,
	output logic                     irq
);

	initial begin
		if (DATA_W != RESULT_W)
			$error("pss_pair_sample: result width must match the core");
	end

	////////////////////////////////////////////////////////////////////////
	// address decode

	function automatic logic is_result(input logic [11:0] a);
		is_result = (a >= ADDR_RESULT_LO) && (a <= ADDR_RESULT_HI) && (a[1:0] == 2'h0);
	endfunction : is_result

	function automatic logic is_mapped(input logic [11:0] a);
		is_mapped = (a == ADDR_PROTECT) || (a == ADDR_STATUS) || (a == ADDR_MASK)
			|| (a == ADDR_MODE) || is_result(a);
	endfunction : is_mapped

	logic                    access;
	logic                    wr_access;
	logic                    rd_access;
	logic                    rd_wait;
	logic                    protected_write_enable;
	logic [NUM_SLOTS-1:0]    status;
	logic [NUM_SLOTS-1:0]    mask;
	logic [RESULT_W-1:0]     mem_rd_data;

	assign access    = psel && penable;
	assign wr_access = access && pwrite && pready;
	assign rd_access = access && !pwrite && pready;

	// result reads wait one cycle for the registered memory port
	assign pready  = !(access && !pwrite && is_result(paddr)) || rd_wait;
	assign pslverr = access && pready && !is_mapped(paddr);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_wait <= 1'b0;
		else
			rd_wait <= access && !pwrite && is_result(paddr) && !rd_wait;
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	// protection gate; software opens it before touching the mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			protected_write_enable <= PROTECT_RESET;
		else if (wr_access && paddr == ADDR_PROTECT)
			protected_write_enable <= pwdata[PROTECT_BIT];
	end

	// pair enables; upper byte is never stored
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pair_sample_mode <= MODE_RESET;
		else if (wr_access && paddr == ADDR_MODE && protected_write_enable)
			pair_sample_mode <= {8'h00, pwdata[MODE_PAIRS-1:0]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mask <= MASK_RESET;
		else if (wr_access && paddr == ADDR_MASK)
			mask <= pwdata[NUM_SLOTS-1:0];
	end

	////////////////////////////////////////////////////////////////////////
	// slot dispatch

	pss_state_t              state;
	logic                    pair_on;
	logic                    cur_coupled;
	logic [SLOT_W-1:0]       cur_slot;
	logic [RESULT_W-1:0]     odd_data;
	logic                    mem_wr_en;
	logic [SLOT_W-1:0]       mem_wr_addr;
	logic [RESULT_W-1:0]     mem_wr_data;
	logic                    take;

	// enable bit k serves slots 2k and 2k+1
	assign pair_on    = pair_sample_mode[slot_req.slot[SLOT_W-1:1]];
	assign slot_ready = (state == ST_IDLE);
	assign take       = slot_req.valid && slot_ready;

	// mode is latched at dispatch so a late change cannot split a pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_cmd    <= '0;
			cur_coupled <= 1'b0;
			cur_slot    <= '0;
		end else begin
			core_cmd.valid <= take;
			if (take) begin
				cur_coupled      <= pair_on;
				core_cmd.coupled <= pair_on;
				if (pair_on) begin
					// pair slot index is the even slot; low bits pick channel pair
					cur_slot        <= {slot_req.slot[SLOT_W-1:1], 1'b0};
					core_cmd.slot   <= {slot_req.slot[SLOT_W-1:1], 1'b0};
					core_cmd.chan_a <= {1'b0, slot_req.input_channel_select[PAIR_CH_W-1:0]};
					core_cmd.chan_b <= {1'b1, slot_req.input_channel_select[PAIR_CH_W-1:0]};
				end else begin
					cur_slot        <= slot_req.slot;
					core_cmd.slot   <= slot_req.slot;
					core_cmd.chan_a <= slot_req.input_channel_select;
					core_cmd.chan_b <= slot_req.input_channel_select;
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= ST_IDLE;
		else begin
			case (state)
				ST_IDLE: begin
					if (take)
						state <= ST_BUSY;
				end
				ST_BUSY: begin
					if (core_rsp.done)
						state <= cur_coupled ? ST_SECOND : ST_IDLE;
				end
				ST_SECOND: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// odd slot result waits one cycle for the single write port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			odd_data <= '0;
		else if (state == ST_BUSY && core_rsp.done)
			odd_data <= core_rsp.data_b;
	end

	always_comb begin
		mem_wr_en   = 1'b0;
		mem_wr_addr = cur_slot;
		mem_wr_data = core_rsp.data_a;
		if (state == ST_BUSY && core_rsp.done) begin
			mem_wr_en = 1'b1;
		end else if (state == ST_SECOND) begin
			mem_wr_en   = 1'b1;
			mem_wr_addr = {cur_slot[SLOT_W-1:1], 1'b1};
			mem_wr_data = odd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// done events and interrupt

	logic [NUM_SLOTS-1:0]    next_events;

	// pair events fire together once both results are stored
	always_comb begin
		next_events = '0;
		if (state == ST_BUSY && core_rsp.done && !cur_coupled)
			next_events[cur_slot] = 1'b1;
		if (state == ST_SECOND) begin
			next_events[{cur_slot[SLOT_W-1:1], 1'b0}] = 1'b1;
			next_events[{cur_slot[SLOT_W-1:1], 1'b1}] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			conversion_done_event <= '0;
		else
			conversion_done_event <= next_events;
	end

	// read clears, but a fresh event in the same cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			status <= STATUS_RESET;
		else if (rd_access && paddr == ADDR_STATUS)
			status <= next_events;
		else
			status <= status | next_events;
	end

	assign irq = |(status & mask);

	////////////////////////////////////////////////////////////////////////
	// result store and read mux

	pss_result_mem #(
		.WIDTH (RESULT_W),
		.DEPTH (NUM_SLOTS)
	) u_result_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.wr_en   (mem_wr_en),
		.wr_addr (mem_wr_addr),
		.wr_data (mem_wr_data),
		.rd_addr (paddr[SLOT_W+1:2]),
		.rd_data (mem_rd_data)
	);

	always_comb begin
		prdata = 32'h0000_0000;
		if (access && !pwrite) begin
			if (paddr == ADDR_PROTECT)
				prdata = {31'h0, protected_write_enable};
			else if (paddr == ADDR_STATUS)
				prdata = {16'h0000, status};
			else if (paddr == ADDR_MASK)
				prdata = {16'h0000, mask};
			else if (paddr == ADDR_MODE)
				prdata = {16'h0000, pair_sample_mode};
			else if (is_result(paddr))
				prdata = {{(32-RESULT_W){1'b0}}, mem_rd_data};
		end
	end

endmodule : pss_pair_sample

/* File: pss_pkg.sv */
/*
 * pss_pkg: shared constants and carriers for the pair sample mode block.
 * Assumes a 32-bit APB register bus and a single system clock domain.
 */
package pss_pkg;

	// word indices as printed; byte address is four times the index
	localparam logic [7:0]  MODE_INDEX      = 8'h12;
	localparam logic [11:0] ADDR_PROTECT    = 12'h000;
	localparam logic [11:0] ADDR_STATUS     = 12'h004;
	localparam logic [11:0] ADDR_MASK       = 12'h008;
	localparam logic [11:0] ADDR_MODE       = {2'h0, MODE_INDEX, 2'h0};
	localparam logic [11:0] ADDR_RESULT_LO  = 12'h080;
	localparam logic [11:0] ADDR_RESULT_HI  = 12'h0bc;

	// field layout
	localparam int          PROTECT_BIT     = 0;
	localparam int          MODE_PAIRS      = 8;
	localparam int          MODE_WIDTH      = 16;
	localparam int          NUM_SLOTS       = 16;
	localparam int          SLOT_W          = 4;
	localparam int          INPUT_CHANNEL_SELECT_W         = 4;
	localparam int          PAIR_CH_W       = 3;
	localparam int          RESULT_W        = 12;

	// reset values
	localparam logic [15:0] MODE_RESET      = 16'h0000;
	localparam logic [15:0] STATUS_RESET    = 16'h0000;
	localparam logic [15:0] MASK_RESET      = 16'h0000;
	localparam logic        PROTECT_RESET   = 1'b0;

	// slot start request from the sequencer
	typedef struct packed {
		logic                 valid;
		logic [SLOT_W-1:0]    slot;
		logic [INPUT_CHANNEL_SELECT_W-1:0]   input_channel_select;
	} pss_slot_req_t;

	// command to the conversion core
	typedef struct packed {
		logic                 valid;
		logic                 coupled;
		logic [SLOT_W-1:0]    slot;
		logic [INPUT_CHANNEL_SELECT_W-1:0]   chan_a;
		logic [INPUT_CHANNEL_SELECT_W-1:0]   chan_b;
	} pss_core_cmd_t;

	// answer from the conversion core
	typedef struct packed {
		logic                 done;
		logic [RESULT_W-1:0]  data_a;
		logic [RESULT_W-1:0]  data_b;
	} pss_core_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_BUSY,
		ST_SECOND
	} pss_state_t;

endpackage : pss_pkg

/* File: pss_result_mem.sv */
/*
 * pss_result_mem: slot result store, one write port and one read port.
 * Assumes a single clock; read data appear one clock after the address.
 */
module pss_result_mem
	import pss_pkg::*;
#(
	parameter int WIDTH = RESULT_W,
	parameter int DEPTH = NUM_SLOTS
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     wr_en,
	input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
	output logic      [WIDTH-1:0]         rd_data
);

	initial begin
		if (WIDTH < 1 || WIDTH > 32 || DEPTH < 2)
			$error("pss_result_mem: unsupported width or depth");
	end

	logic [WIDTH-1:0] store [DEPTH];

	// storage has no reset; results are undefined until first written
	always_ff @(posedge pclk) begin
		if (wr_en)
			store[wr_addr] <= wr_data;
	end

	// registered read port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rd_data <= '0;
		else
			rd_data <= store[rd_addr];
	end

endmodule : pss_result_mem

/* File: pss_pair_sample_sva.sv */
/*
 * checker for the pair sample mode block, ports only.
 * assumes one clock, async active-low reset.
 */
module pss_pair_sample_sva
	import pss_pkg::*;
(
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [11:0]         paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire pss_slot_req_t       slot_req,
	input wire logic                slot_ready,
	input wire pss_core_cmd_t       core_cmd,
	input wire pss_core_rsp_t       core_rsp,
	input wire logic [NUM_SLOTS-1:0] conversion_done_event,
	input wire logic [MODE_WIDTH-1:0] pair_sample_mode,
	input wire logic                irq
);
	logic prot;
	wire logic wr_acc = psel && penable && pready && pwrite;
	wire logic pair_sel = pair_sample_mode[slot_req.slot[3:1]];

	// shadow of the protect bit, not a port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prot <= 1'b0;
		else if (wr_acc && paddr == ADDR_PROTECT)
			prot <= pwdata[PROTECT_BIT];
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rsv; pair_sample_mode[15:8] == 8'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits set");
	property p_lock; wr_acc && paddr == ADDR_MODE && !prot |=> $stable(pair_sample_mode); endproperty
	a_lock: assert property (p_lock) else $error("unprotected write took");
	property p_load;
		wr_acc && paddr == ADDR_MODE && prot |=> pair_sample_mode == {8'h00, $past(pwdata[7:0])};
	endproperty
	a_load: assert property (p_load) else $error("mode write lost");
	property p_cmd;
		slot_req.valid && slot_ready |=> core_cmd.valid && core_cmd.coupled == $past(pair_sel);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command mode wrong");
	property p_cpl;
		core_cmd.valid && core_cmd.coupled |-> !core_cmd.slot[0] && !core_cmd.chan_a[3]
			&& core_cmd.chan_b == {1'b1, core_cmd.chan_a[2:0]};
	endproperty
	a_cpl: assert property (p_cpl) else $error("pair decode wrong");
	property p_sgl;
		slot_req.valid && slot_ready && !pair_sel |=>
			core_cmd.chan_a == $past(slot_req.input_channel_select) && core_cmd.slot == $past(slot_req.slot);
	endproperty
	a_sgl: assert property (p_sgl) else $error("single decode wrong");
	property p_ev1; core_rsp.done && !core_cmd.coupled |=> conversion_done_event == 16'h0001 << core_cmd.slot; endproperty
	a_ev1: assert property (p_ev1) else $error("single event wrong");
	property p_ev2;
		core_rsp.done && core_cmd.coupled |=> conversion_done_event == 16'h0000
			##1 conversion_done_event == 16'h0003 << core_cmd.slot;
	endproperty
	a_ev2: assert property (p_ev2) else $error("pair event wrong");
	property p_once; |conversion_done_event |=> conversion_done_event == 16'h0000; endproperty
	a_once: assert property (p_once) else $error("event longer than a pulse");
endmodule : pss_pair_sample_sva

bind pss_pair_sample pss_pair_sample_sva pss_pair_sample_sva_i (.*);

/* File: test_pss_pair_sample.sv */
/*
 * self-checking bench for the pair sample mode block.
 * assumes the bench plays APB master, sequencer and conversion core.
 */
module test_pss_pair_sample
	import pss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] MODE_SET = 8'ha5;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, slot_ready, irq;
	pss_slot_req_t slot_req = '0;
	pss_core_cmd_t core_cmd;
	pss_core_rsp_t core_rsp = '0;
	logic [15:0] conversion_done_event, pair_sample_mode, stat = 16'h0;
	int n_errors = 0, tests_run = 0;

	pss_pair_sample pss_pair_sample_i (.*);
	always #2.5 pclk = ~pclk;

	////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task final_report;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	// ready and data are taken at the rising edge that completes the access
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int n;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			n_errors++;
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(r, exp);
	endtask : rd
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	////////////////////////////////////////////////////////////////
	task t_regs;
		logic [31:0] r;
		logic e;
		rd(ADDR_MODE, {16'h0, MODE_RESET});
		wr(ADDR_MODE, 32'h0000_00ff);
		rd(ADDR_MODE, 32'h0);
		wr(ADDR_PROTECT, 32'h1);
		wr(ADDR_MODE, {24'hffffff, MODE_SET});
		rd(ADDR_MODE, {24'h0, MODE_SET});
		chk(pair_sample_mode, {24'h0, MODE_SET});
		apb(1'b0, 12'h0f0, 32'h0, r, e);
		chk(e, 32'h1);
	endtask : t_regs
	// one conversion on the odd slot of pair k
	task conv(input int k, input logic cpl);
		logic [3:0] s;
		logic [11:0] da, db;
		logic [15:0] ev;
		int n;
		s = 4'(2 * k + 1);
		da = 12'h100 + 12'(k);
		db = 12'h200 + 12'(k);
		ev = cpl ? 16'h3 << (2 * k) : 16'h2 << (2 * k);
		@(posedge pclk);
		slot_req <= '{1'b1, s, 4'hd};
		@(posedge pclk);
		slot_req.valid <= 1'b0;
		@(negedge pclk);
		chk(core_cmd, {1'b1, cpl, cpl ? (s & 4'he) : s, cpl ? 4'h5 : 4'hd, 4'hd});
		@(posedge pclk);
		core_rsp <= '{1'b1, da, db};
		@(posedge pclk);
		core_rsp.done <= 1'b0;
		n = 0;
		while (conversion_done_event === 16'h0 && n < 8) begin
			@(negedge pclk);
			n++;
		end
		chk(conversion_done_event, ev);
		stat |= ev;
		rd(ADDR_RESULT_LO + 12'(8 * k + 4), {20'h0, cpl ? db : da});
		if (cpl)
			rd(ADDR_RESULT_LO + 12'(8 * k), {20'h0, da});
	endtask : conv
	task t_conv;
		for (int k = 0; k < 8; k++)
			conv(k, MODE_SET[k]);
	endtask : t_conv
	task t_irq;
		chk(irq, 32'h0);
		wr(ADDR_MASK, 32'hffff);
		@(negedge pclk);
		chk(irq, 32'h1);
		rd(ADDR_STATUS, {16'h0, stat});
		rd(ADDR_STATUS, 32'h0);
		chk(irq, 32'h0);
	endtask : t_irq

	////////////////////////////////////////////////////////////////
	// main sequence, reset held two cycles
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_conv;
		t_irq;
		final_report;
	end
	// watchdog, well above the 120 or so cycles needed
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		final_report;
	end
endmodule : test_pss_pair_sample
